// [common/iodec_pkg.sv]
package iodec_pkg;

    // ------------------------------------------------------------
    // address space
    // ------------------------------------------------------------
    localparam int          IODEC_AW        = 6;     // i/o address width
    localparam int          IODEC_DW        = 8;     // register width
    localparam int          IODEC_NREG      = 64;    // i/o locations
    localparam logic [5:0]  IODEC_BIT_LAST  = 6'h1F; // last bit-op address
    localparam logic [5:0]  IODEC_IO_LAST   = 6'h3F; // last in/out address
    localparam logic [7:0]  IODEC_DS_OFFSET = 8'h20; // data = io + offset
    localparam logic [7:0]  IODEC_DS_IO_LO  = 8'h20; // data window start
    localparam logic [7:0]  IODEC_DS_IO_HI  = 8'h5F; // data window end
    localparam logic [7:0]  IODEC_DS_EXT_LO = 8'h60; // extended space start
    localparam logic [7:0]  IODEC_DS_EXT_HI = 8'hFF; // extended space end

    // ------------------------------------------------------------
    // register offsets (i/o addresses)
    // ------------------------------------------------------------
    localparam logic [5:0]  IODEC_PORT_B_PIN   = 6'h03;
    localparam logic [5:0]  IODEC_PORT_B_DIR   = 6'h04;
    localparam logic [5:0]  IODEC_PORT_B_OUT   = 6'h05;
    localparam logic [5:0]  IODEC_PORT_C_PIN   = 6'h06;
    localparam logic [5:0]  IODEC_PORT_C_DIR   = 6'h07;
    localparam logic [5:0]  IODEC_PORT_C_OUT   = 6'h08;
    localparam logic [5:0]  IODEC_PORT_D_PIN   = 6'h09;
    localparam logic [5:0]  IODEC_PORT_D_DIR   = 6'h0A;
    localparam logic [5:0]  IODEC_PORT_D_OUT   = 6'h0B;
    localparam logic [5:0]  IODEC_PORT_E_PIN   = 6'h0C;
    localparam logic [5:0]  IODEC_PORT_E_DIR   = 6'h0D;
    localparam logic [5:0]  IODEC_PORT_E_OUT   = 6'h0E;
    localparam logic [5:0]  IODEC_T0_FLAGS     = 6'h15;
    localparam logic [5:0]  IODEC_T1_FLAGS     = 6'h16;
    localparam logic [5:0]  IODEC_SCRATCH_1    = 6'h19;
    localparam logic [5:0]  IODEC_SCRATCH_2    = 6'h1A;
    localparam logic [5:0]  IODEC_SCRATCH_0    = 6'h1E;
    localparam logic [5:0]  IODEC_NV_CTRL      = 6'h1F;
    localparam logic [5:0]  IODEC_NV_DATA      = 6'h20;
    localparam logic [5:0]  IODEC_NV_ADDR_LO   = 6'h21;
    localparam logic [5:0]  IODEC_NV_ADDR_HI   = 6'h22;
    localparam logic [5:0]  IODEC_GTIMER_CTRL  = 6'h23;
    localparam logic [5:0]  IODEC_T0_CTRL_A    = 6'h24;
    localparam logic [5:0]  IODEC_T0_CTRL_B    = 6'h25;
    localparam logic [5:0]  IODEC_T0_COUNT     = 6'h26;
    localparam logic [5:0]  IODEC_T0_CMP_A     = 6'h27;
    localparam logic [5:0]  IODEC_T0_CMP_B     = 6'h28;
    localparam logic [5:0]  IODEC_PLL_CS       = 6'h29;
    localparam logic [5:0]  IODEC_SER_CTRL     = 6'h2C;
    localparam logic [5:0]  IODEC_SER_STAT     = 6'h2D;
    localparam logic [5:0]  IODEC_SER_DATA     = 6'h2E;
    localparam logic [5:0]  IODEC_CMP_STAT     = 6'h2F;

    // ------------------------------------------------------------
    // field masks and reset value
    // ------------------------------------------------------------
    localparam logic [7:0]  IODEC_MASK_FULL    = 8'hFF;
    localparam logic [7:0]  IODEC_MASK_PORT_E  = 8'h07; // three pins
    localparam logic [7:0]  IODEC_MASK_T0_FLG  = 8'h07; // cmp b, cmp a, ovf
    localparam logic [7:0]  IODEC_MASK_T1_FLG  = 8'h27; // capt, cmps, ovf
    localparam logic [7:0]  IODEC_RESET_VAL    = 8'h00;

endpackage

// [rtl/iodec_top.sv]
`timescale 1ns/1ns

module iodec_top
(
    input  wire logic       clk,              // core clock, 25 MHz
    input  wire logic       rst_b,            // async reset, active low
    // i/o in/out instructions
    input  wire logic [5:0] io_addr,          // i/o address
    input  wire logic       io_rd,            // in instruction strobe
    input  wire logic       io_wr,            // out instruction strobe
    input  wire logic [7:0] io_wdata,         // out data
    // data-space load/store
    input  wire logic [7:0] ds_addr,          // data-space address
    input  wire logic       ds_rd,            // load strobe
    input  wire logic       ds_wr,            // store strobe
    input  wire logic [7:0] ds_wdata,         // store data
    // single-bit instructions
    input  wire logic [5:0] bit_addr,         // i/o address of bit op
    input  wire logic [2:0] bit_sel,          // bit number
    input  wire logic       set_io_bit_instr, // set bit strobe
    input  wire logic       clear_io_bit_instr, // clear bit strobe
    input  wire logic       skip_if_io_bit_set, // test, skip if set
    input  wire logic       skip_if_io_bit_clear, // test, skip if clear
    // peripheral side
    input  wire logic [7:0] pin_b,            // port b pins, async
    input  wire logic [7:0] pin_c,            // port c pins, async
    input  wire logic [7:0] pin_d,            // port d pins, async
    input  wire logic [2:0] pin_e,            // port e pins, async
    input  wire logic [7:0] t0_flag_set,      // timer0 flag events
    input  wire logic [7:0] t1_flag_set,      // timer1 flag events
    // answers
    output logic [7:0]      rd_data_q,        // read data
    output logic            rd_valid_q,       // read data valid pulse
    output logic            skip_q,           // skip decision
    output logic            skip_valid_q,     // skip decision valid pulse
    output logic            bit_reject_q,     // bit op out of range pulse
    output logic            wr_ignored_q,     // write to unmapped pulse
    output logic [7:0]      port_b_dir_q,     // port b direction
    output logic [7:0]      port_b_out_q,     // port b output
    output logic [7:0]      port_c_dir_q,     // port c direction
    output logic [7:0]      port_c_out_q,     // port c output
    output logic [7:0]      port_d_dir_q,     // port d direction
    output logic [7:0]      port_d_out_q,     // port d output
    output logic [2:0]      port_e_dir_q,     // port e direction
    output logic [2:0]      port_e_out_q,     // port e output
    output logic [7:0]      t0_flags_q,       // timer0 flags
    output logic [7:0]      t1_flags_q        // timer1 flags
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------

    // implemented bits of each location, zero where reserved
    function automatic logic [7:0] impl_mask(input logic [5:0] a);
        logic [7:0] m;
        m = 8'h00;
        unique case (a)
            iodec_pkg::IODEC_PORT_B_PIN,
            iodec_pkg::IODEC_PORT_B_DIR,
            iodec_pkg::IODEC_PORT_B_OUT,
            iodec_pkg::IODEC_PORT_C_PIN,
            iodec_pkg::IODEC_PORT_C_DIR,
            iodec_pkg::IODEC_PORT_C_OUT,
            iodec_pkg::IODEC_PORT_D_PIN,
            iodec_pkg::IODEC_PORT_D_DIR,
            iodec_pkg::IODEC_PORT_D_OUT,
            iodec_pkg::IODEC_SCRATCH_0,
            iodec_pkg::IODEC_SCRATCH_1,
            iodec_pkg::IODEC_SCRATCH_2,
            iodec_pkg::IODEC_NV_CTRL,
            iodec_pkg::IODEC_NV_DATA,
            iodec_pkg::IODEC_NV_ADDR_LO,
            iodec_pkg::IODEC_NV_ADDR_HI,
            iodec_pkg::IODEC_GTIMER_CTRL,
            iodec_pkg::IODEC_T0_CTRL_A,
            iodec_pkg::IODEC_T0_CTRL_B,
            iodec_pkg::IODEC_T0_COUNT,
            iodec_pkg::IODEC_T0_CMP_A,
            iodec_pkg::IODEC_T0_CMP_B,
            iodec_pkg::IODEC_PLL_CS,
            iodec_pkg::IODEC_SER_CTRL,
            iodec_pkg::IODEC_SER_STAT,
            iodec_pkg::IODEC_SER_DATA,
            iodec_pkg::IODEC_CMP_STAT:
                m = iodec_pkg::IODEC_MASK_FULL;
            iodec_pkg::IODEC_PORT_E_PIN,
            iodec_pkg::IODEC_PORT_E_DIR,
            iodec_pkg::IODEC_PORT_E_OUT:
                m = iodec_pkg::IODEC_MASK_PORT_E;
            iodec_pkg::IODEC_T0_FLAGS:
                m = iodec_pkg::IODEC_MASK_T0_FLG;
            iodec_pkg::IODEC_T1_FLAGS:
                m = iodec_pkg::IODEC_MASK_T1_FLG;
            default:
                m = 8'h00;
        endcase
        return m;
    endfunction

    // pin readback locations hold no storage
    function automatic logic is_pin(input logic [5:0] a);
        return (a == iodec_pkg::IODEC_PORT_B_PIN) ||
               (a == iodec_pkg::IODEC_PORT_C_PIN) ||
               (a == iodec_pkg::IODEC_PORT_D_PIN) ||
               (a == iodec_pkg::IODEC_PORT_E_PIN);
    endfunction

    // write-one-to-clear locations
    function automatic logic is_w1c(input logic [5:0] a);
        return (a == iodec_pkg::IODEC_T0_FLAGS) ||
               (a == iodec_pkg::IODEC_T1_FLAGS);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [7:0] pb_s1_q, pb_s2_q;
    logic [7:0] pc_s1_q, pc_s2_q;
    logic [7:0] pd_s1_q, pd_s2_q;
    logic [2:0] pe_s1_q, pe_s2_q;

    // two flops before anything reads the pins
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pb_s1_q <= 8'h00;
            pb_s2_q <= 8'h00;
            pc_s1_q <= 8'h00;
            pc_s2_q <= 8'h00;
            pd_s1_q <= 8'h00;
            pd_s2_q <= 8'h00;
            pe_s1_q <= 3'h0;
            pe_s2_q <= 3'h0;
        end
        else
        begin
            pb_s1_q <= pin_b;
            pb_s2_q <= pb_s1_q;
            pc_s1_q <= pin_c;
            pc_s2_q <= pc_s1_q;
            pd_s1_q <= pin_d;
            pd_s2_q <= pd_s1_q;
            pe_s1_q <= pin_e;
            pe_s2_q <= pe_s1_q;
        end
    end

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    logic [7:0] regs_q [iodec_pkg::IODEC_NREG];

    // data-space window onto i/o space, extended space left unmapped
    wire        ds_in_io  = (ds_addr >= iodec_pkg::IODEC_DS_IO_LO) &&
                            (ds_addr <= iodec_pkg::IODEC_DS_IO_HI);
    wire        ds_in_ext = (ds_addr >= iodec_pkg::IODEC_DS_EXT_LO);
    wire [7:0]  ds_io_full = ds_addr - iodec_pkg::IODEC_DS_OFFSET;
    wire [5:0]  ds_io_addr = ds_io_full[5:0];

    // in/out reach 0x00-0x3F by the width of their address
    wire        io_acc    = io_rd | io_wr;
    wire        ds_acc    = (ds_rd | ds_wr) & ~io_acc;
    wire        bit_op    = (set_io_bit_instr | clear_io_bit_instr) &
                            ~io_acc & ~ds_acc;
    wire        bit_tst   = (skip_if_io_bit_set | skip_if_io_bit_clear) &
                            ~io_acc & ~ds_acc;
    wire        bit_inrng = (bit_addr <= iodec_pkg::IODEC_BIT_LAST);
    wire        bit_wr    = bit_op & bit_inrng;
    wire [7:0]  bit_hot   = 8'h01 << bit_sel;

    // unified access target
    wire [5:0]  acc_addr  = io_acc ? io_addr :
                            ds_acc ? ds_io_addr : bit_addr;
    wire        wr_en     = (io_acc & io_wr) |
                            (ds_acc & ds_wr & ds_in_io) | bit_wr;
    wire        rd_en     = (io_acc & io_rd & ~io_wr) |
                            (ds_acc & ds_rd & ~ds_wr);
    // set-bit ops write a one-hot value, clear-bit ops write zero, under a one-hot mask
    wire [7:0]  wr_data   = io_acc ? io_wdata :
                            ds_acc ? ds_wdata :
                            (set_io_bit_instr ? bit_hot : 8'h00);
    wire [7:0]  wr_lane   = bit_wr ? bit_hot : 8'hFF;
    wire [7:0]  wr_mask   = wr_lane & impl_mask(acc_addr);
    wire        wr_store  = wr_en & ~is_pin(acc_addr) &
                            (impl_mask(acc_addr) != 8'h00);
    wire        wr_unmap  = wr_en & ~wr_store;

    // ------------------------------------------------------------
    // read value
    // ------------------------------------------------------------
    logic [7:0] rd_val;

    // pins read through the synchronisers, reserved reads zero
    always_comb
    begin
        unique case (acc_addr)
            iodec_pkg::IODEC_PORT_B_PIN: rd_val = pb_s2_q;
            iodec_pkg::IODEC_PORT_C_PIN: rd_val = pc_s2_q;
            iodec_pkg::IODEC_PORT_D_PIN: rd_val = pd_s2_q;
            iodec_pkg::IODEC_PORT_E_PIN: rd_val = {5'h00, pe_s2_q};
            default:                     rd_val = regs_q[acc_addr];
        endcase
        rd_val = rd_val & impl_mask(acc_addr);
    end

    // load from extended or window-outside space returns zero
    wire        rd_mapped = io_acc | (ds_acc & ds_in_io);
    wire [7:0]  rd_word   = rd_mapped ? rd_val : 8'h00;
    wire        bit_now   = |(rd_val & bit_hot);
    wire        skip_now  = skip_if_io_bit_set ? bit_now : ~bit_now;

    // ------------------------------------------------------------
    // hardware flag events
    // ------------------------------------------------------------
    wire [7:0]  t0_evt    = t0_flag_set & iodec_pkg::IODEC_MASK_T0_FLG;
    wire [7:0]  t1_evt    = t1_flag_set & iodec_pkg::IODEC_MASK_T1_FLG;

    // ------------------------------------------------------------
    // register array
    // ------------------------------------------------------------

    // plain bits merge under mask, one-to-clear bits clear on ones,
    // and a hardware event in the same cycle wins over the clear
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < iodec_pkg::IODEC_NREG; i++)
                regs_q[i] <= iodec_pkg::IODEC_RESET_VAL;
        end
        else
        begin
            for (int i = 0; i < iodec_pkg::IODEC_NREG; i++)
            begin
                if (is_w1c(6'(i)))
                begin
                    regs_q[i] <= (regs_q[i] &
                        ~((wr_store && acc_addr == 6'(i)) ?
                          (wr_data & wr_mask) : 8'h00)) |
                        ((6'(i) == iodec_pkg::IODEC_T0_FLAGS) ?
                          t0_evt : t1_evt);
                end
                else if (wr_store && acc_addr == 6'(i))
                begin
                    regs_q[i] <= (regs_q[i] & ~wr_mask) |
                                 (wr_data & wr_mask);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // answers
    // ------------------------------------------------------------

    // read data and skip result one cycle after the strobe
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_data_q    <= 8'h00;
            rd_valid_q   <= 1'b0;
            skip_q       <= 1'b0;
            skip_valid_q <= 1'b0;
        end
        else
        begin
            rd_valid_q   <= rd_en;
            skip_valid_q <= bit_tst & bit_inrng;
            if (rd_en)
                rd_data_q <= rd_word;
            if (bit_tst)
                skip_q <= bit_inrng & skip_now;
        end
    end

    // refusal indications
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bit_reject_q <= 1'b0;
            wr_ignored_q <= 1'b0;
        end
        else
        begin
            bit_reject_q <= (bit_op | bit_tst) & ~bit_inrng;
            wr_ignored_q <= wr_unmap | (ds_acc & ds_wr &
                            (ds_in_ext | ~ds_in_io));
        end
    end

    // ------------------------------------------------------------
    // peripheral-side views of the stored registers
    // ------------------------------------------------------------
    assign port_b_dir_q = regs_q[iodec_pkg::IODEC_PORT_B_DIR];
    assign port_b_out_q = regs_q[iodec_pkg::IODEC_PORT_B_OUT];
    assign port_c_dir_q = regs_q[iodec_pkg::IODEC_PORT_C_DIR];
    assign port_c_out_q = regs_q[iodec_pkg::IODEC_PORT_C_OUT];
    assign port_d_dir_q = regs_q[iodec_pkg::IODEC_PORT_D_DIR];
    assign port_d_out_q = regs_q[iodec_pkg::IODEC_PORT_D_OUT];
    assign port_e_dir_q = regs_q[iodec_pkg::IODEC_PORT_E_DIR][2:0];
    assign port_e_out_q = regs_q[iodec_pkg::IODEC_PORT_E_OUT][2:0];
    assign t0_flags_q   = regs_q[iodec_pkg::IODEC_T0_FLAGS];
    assign t1_flags_q   = regs_q[iodec_pkg::IODEC_T1_FLAGS];

endmodule

// [testbench/iodec_checker.sv]
`timescale 1ns/1ns

// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module iodec_checker
(
    input  wire logic       clk,                  // core clock
    input  wire logic       rst_b,                // async reset
    input  wire logic [5:0] io_addr,              // i/o address
    input  wire logic       io_rd,                // in strobe
    input  wire logic       io_wr,                // out strobe
    input  wire logic [7:0] io_wdata,             // out data
    input  wire logic [7:0] ds_addr,              // data address
    input  wire logic       ds_rd,                // load strobe
    input  wire logic       ds_wr,                // store strobe
    input  wire logic [7:0] ds_wdata,             // store data
    input  wire logic [5:0] bit_addr,             // bit op address
    input  wire logic [2:0] bit_sel,              // bit number
    input  wire logic       set_io_bit_instr,     // set bit
    input  wire logic       clear_io_bit_instr,   // clear bit
    input  wire logic       skip_if_io_bit_set,   // test set
    input  wire logic       skip_if_io_bit_clear, // test clear
    input  wire logic [7:0] t0_flag_set,          // timer0 events
    input  wire logic       rd_valid_q,           // read valid
    input  wire logic       skip_q,               // skip result
    input  wire logic       skip_valid_q,         // skip valid
    input  wire logic       bit_reject_q,         // bit op refused
    input  wire logic       wr_ignored_q,         // write dropped
    input  wire logic [7:0] port_b_out_q,         // port b output
    input  wire logic [7:0] t0_flags_q            // timer0 flags
);
    // bit request alone in its cycle
    wire bus_idle = !(io_rd || io_wr || ds_rd || ds_wr);
    wire one_bit  = bus_idle && $onehot({set_io_bit_instr, clear_io_bit_instr,
                    skip_if_io_bit_set, skip_if_io_bit_clear});

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // named single-cycle requests and the skip-value property
    sequence s_set_port_b;
        one_bit && set_io_bit_instr && bit_addr == 6'h05;
    endsequence
    sequence s_flag_clr;
        io_wr && io_addr == 6'h15 && io_wdata[0] && !t0_flag_set[0];
    endsequence
    property p_skip_value;
        one_bit && skip_if_io_bit_set && bit_addr == 6'h05 |=> skip_valid_q
            && skip_q == |($past(port_b_out_q) & (8'h01 << $past(bit_sel)));
    endproperty

    a_read_answer:
    assert property (io_rd && !io_wr |=> rd_valid_q)
        else $error("in access not answered");
    a_bit_reject:
    assert property (one_bit && bit_addr > 6'h1F |=> bit_reject_q
        && !skip_valid_q) else $error("bit op out of range taken");
    a_bit_accept:
    assert property (one_bit && bit_addr <= 6'h1F |=> !bit_reject_q)
        else $error("bit op in range refused");
    a_skip_value:
    assert property (p_skip_value) else $error("wrong skip result");
    a_flag_clear:
    assert property (s_flag_clr |=> !t0_flags_q[0])
        else $error("flag not cleared by one");
    a_flag_keep:
    assert property (io_wr && io_addr == 6'h15 && !io_wdata[0]
        && t0_flags_q[0] |=> t0_flags_q[0]) else $error("flag lost on zero");
    a_setbit_only:
    assert property (s_set_port_b |=> port_b_out_q == ($past(port_b_out_q)
        | (8'h01 << $past(bit_sel)))) else $error("bit set touched others");
    a_store_map:
    assert property (ds_wr && bus_idle == 1'b0 && !io_rd && !io_wr
        && ds_addr == 8'h25 |=> port_b_out_q == $past(ds_wdata))
        else $error("store not mapped at offset");
    a_ext_ignored:
    assert property (ds_wr && !io_rd && !io_wr && ds_addr >= 8'h60
        |=> wr_ignored_q && $stable(port_b_out_q))
        else $error("extended store reached i/o");
endmodule

bind iodec_top iodec_checker i_iodec_checker (.clk, .rst_b, .io_addr,
    .io_rd, .io_wr, .io_wdata, .ds_addr, .ds_rd, .ds_wr, .ds_wdata, .bit_addr,
    .bit_sel, .set_io_bit_instr, .clear_io_bit_instr, .skip_if_io_bit_set,
    .skip_if_io_bit_clear, .t0_flag_set, .rd_valid_q, .skip_q, .skip_valid_q,
    .bit_reject_q, .wr_ignored_q, .port_b_out_q, .t0_flags_q);

// [testbench/iodec_core_model.sv]
`timescale 1ns/1ns

// ------------------------------------------------------------
// core access model
// ------------------------------------------------------------
module iodec_core_model
(
    input  wire logic       clk,        // core clock
    input  wire logic       rd_valid_q, // read answer valid
    input  wire logic [7:0] rd_data_q,  // read answer data
    input  wire logic [2:0] bit_ans,    // reject, skip valid, skip
    output logic [7:0]      addr,       // i/o, data or bit address
    output logic [7:0]      wdata,      // write data
    output logic [2:0]      bsel,       // bit number
    output logic [7:0]      strb        // one-hot request strobes
);
    // idle before reset release
    initial
    begin
        addr  = 8'h00;
        wdata = 8'h00;
        bsel  = 3'h0;
        strb  = 8'h00;
    end

    // one request for one edge, then released lines flip
    task automatic req(input logic [2:0] k, input logic [7:0] a,
                       input logic [7:0] d, input logic [2:0] s,
                       output logic [7:0] q);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        bsel  <= s;
        strb  <= 8'h01 << k;
        @(posedge clk);
        strb  <= 8'h00;
        addr  <= ~a;
        wdata <= ~d;
        bsel  <= ~s;
        @(negedge clk);
        q = (k >= 3'h4) ? {5'h00, bit_ans} : (rd_valid_q ? rd_data_q : 8'hXX);
    endtask
endmodule

// [testbench/iodec_top_tb.sv]
`timescale 1ns/1ns

// ------------------------------------------------------------
// testbench
// ------------------------------------------------------------
module iodec_top_tb;
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic [7:0] t0_flag_set = 8'h00;
    logic [7:0] t1_flag_set = 8'h00;
    logic [7:0] pin_b = 8'hA5, pin_c = 8'h3C, pin_d = 8'h96;
    logic [2:0] pin_e = 3'h5;
    logic [7:0] addr, wdata, strb, q, rd_data_q, port_b_out_q;
    logic [7:0] t0_flags_q, t1_flags_q;
    logic [7:0] port_b_dir_q, port_c_dir_q, port_c_out_q;
    logic [7:0] port_d_dir_q, port_d_out_q;
    logic [2:0] bsel, port_e_out_q, port_e_dir_q;
    logic       rd_valid_q, skip_q, skip_valid_q, bit_reject_q, wr_ignored_q;
    logic [7:0] sa [3] = '{8'h19, 8'h1A, 8'h1E};
    int         err_count = 0;
    int         compares = 0;

    // 25 MHz core clock
    always #20 clk = ~clk;

    iodec_top i_iodec_top (.clk, .rst_b, .io_addr(addr[5:0]), .io_rd(strb[0]),
        .io_wr(strb[1]), .io_wdata(wdata), .ds_addr(addr), .ds_rd(strb[2]),
        .ds_wr(strb[3]), .ds_wdata(wdata), .bit_addr(addr[5:0]),
        .bit_sel(bsel), .set_io_bit_instr(strb[4]),
        .clear_io_bit_instr(strb[5]), .skip_if_io_bit_set(strb[6]),
        .skip_if_io_bit_clear(strb[7]), .pin_b, .pin_c, .pin_d, .pin_e,
        .t0_flag_set, .t1_flag_set, .rd_data_q, .rd_valid_q, .skip_q,
        .skip_valid_q, .bit_reject_q, .wr_ignored_q, .port_b_dir_q,
        .port_b_out_q, .port_c_dir_q, .port_c_out_q, .port_d_dir_q,
        .port_d_out_q, .port_e_dir_q, .port_e_out_q, .t0_flags_q,
        .t1_flags_q);

    iodec_core_model i_iodec_core_model (.clk, .rd_valid_q, .rd_data_q,
        .bit_ans({bit_reject_q, skip_valid_q, skip_q}), .addr, .wdata, .bsel,
        .strb);

    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask

    task automatic results();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // access wrappers
    task automatic wr(input logic ds, input logic [7:0] a, input logic [7:0] d);
        i_iodec_core_model.req(ds ? 3'h3 : 3'h1, a, d, 3'h0, q);
    endtask
    task automatic rdc(input logic ds, input logic [7:0] a,
                       input logic [7:0] e);
        i_iodec_core_model.req(ds ? 3'h2 : 3'h0, a, 8'h00, 3'h0, q);
        check(q, e);
    endtask
    task automatic bop(input logic [1:0] k, input logic [7:0] a,
                       input logic [2:0] s, input logic [7:0] m,
                       input logic [7:0] e);
        i_iodec_core_model.req(3'h4 + 3'(k), a, 8'h00, s, q);
        check(q & m, e);
    endtask

    // hang guard
    initial
    begin
        #200000;
        err_count++;
        results();
    end

    // main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rdc(0, 8'h1E, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            wr(0, sa[i], 8'hC3 + 8'(i));
            rdc(1, sa[i] + 8'h20, 8'hC3 + 8'(i));
        end
        wr(1, 8'h25, 8'hAA);
        check(port_b_out_q, 8'hAA);
        check(8'(wr_ignored_q), 8'h00);
        rdc(0, 8'h05, 8'hAA);
        bop(0, 8'h05, 3'h0, 8'h06, 8'h00);
        check(port_b_out_q, 8'hAB);
        bop(1, 8'h05, 3'h7, 8'h06, 8'h00);
        check(port_b_out_q, 8'h2B);
        bop(2, 8'h05, 3'h0, 8'h07, 8'h03);
        bop(3, 8'h05, 3'h1, 8'h07, 8'h02);
        for (int k = 0; k < 4; k++)
            bop(2'(k), 8'h25, 3'h0, 8'h06, 8'h04);
        rdc(0, 8'h25, 8'h00);
        @(posedge clk);
        t0_flag_set <= 8'hFF;
        t1_flag_set <= 8'hFF;
        @(posedge clk);
        t0_flag_set <= 8'h00;
        t1_flag_set <= 8'h00;
        @(negedge clk);
        check(t0_flags_q, 8'h07);
        check(t1_flags_q, 8'h27);
        bop(0, 8'h15, 3'h1, 8'h06, 8'h00);
        check(t0_flags_q, 8'h05);
        bop(1, 8'h15, 3'h0, 8'h06, 8'h00);
        check(t0_flags_q, 8'h05);
        wr(0, 8'h15, 8'h00);
        check(t0_flags_q, 8'h05);
        wr(0, 8'h15, 8'h01);
        check(t0_flags_q, 8'h04);
        wr(1, 8'h36, 8'h20);
        check(t1_flags_q, 8'h07);
        wr(1, 8'h65, 8'h55);
        check(8'(wr_ignored_q), 8'h01);
        wr(1, 8'h05, 8'h55);
        check(8'(wr_ignored_q), 8'h01);
        check(port_b_out_q, 8'h2B);
        rdc(1, 8'h65, 8'h00);
        // store below the window; reserved i/o places are only read
        wr(1, 8'h10, 8'hFF);
        check(8'(wr_ignored_q), 8'h01);
        rdc(0, 8'h30, 8'h00);
        rdc(0, 8'h09, 8'h96);
        wr(0, 8'h09, 8'h00);
        check(8'(wr_ignored_q), 8'h01);
        rdc(0, 8'h09, 8'h96);
        rdc(1, 8'h23, 8'hA5);
        rdc(0, 8'h0C, 8'h05);
        wr(0, 8'h0E, 8'h07);
        check(8'(port_e_out_q), 8'h07);
        rdc(1, 8'h2E, 8'h07);
        // direction registers of every port, output registers of ports c and d
        wr(0, 8'h04, 8'h5A);
        check(port_b_dir_q, 8'h5A);
        wr(1, 8'h27, 8'h3C);
        check(port_c_dir_q, 8'h3C);
        wr(0, 8'h08, 8'hC3);
        check(port_c_out_q, 8'hC3);
        wr(1, 8'h2A, 8'h69);
        check(port_d_dir_q, 8'h69);
        wr(0, 8'h0B, 8'h96);
        check(port_d_out_q, 8'h96);
        wr(0, 8'h0D, 8'h05);
        check(8'(port_e_dir_q), 8'h05);
        results();
    end
endmodule
